// ---- hdl/ecb_bus_cycle.sv ----
`timescale 1ns/1ps
module ecb_bus_cycle #(
	parameter int SYNC_STAGES = ecb_pkg::ECB_SYNC_STAGES
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Access requests from the core
	input wire logic req_valid_i,
	input wire ecb_pkg::ecb_req_t req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [ecb_pkg::ECB_DATA_W-1:0] rdata_o,
	// Per chip-select configuration
	input wire ecb_pkg::ecb_phase_timing_config_t cfg_i [ecb_pkg::ECB_NUM_CS],
	// Reference clock control
	input wire logic bus_reference_clock_en_i,
	output logic clock_output_pin_signal_o,
	output logic clk_hs_drv_o,
	// Bus pins
	output ecb_pkg::ecb_pins_t pins_o,
	input wire logic [ecb_pkg::ECB_DATA_W-1:0] shared_address_data_lines_i,
	input wire logic [ecb_pkg::ECB_DATA_W-1:0] separate_data_lines_i,
	input wire logic ready_i
);
	ecb_pkg::ecb_state_t st;
	ecb_pkg::ecb_state_t nx;
	ecb_pkg::ecb_phase_timing_config_t cfg;
	logic rdy_s;
	logic rdy_act;
	logic step_done;
	logic [2:0] new_cs;
	logic [7:0] pc;

	////////////////////////////////////////////////////////////////////////////////
	// Cycles a phase takes; zero means the phase is skipped
	function automatic logic [5:0] phase_len(input ecb_pkg::ecb_phase_t ph,
			input ecb_pkg::ecb_phase_timing_config_t c, input logic chg);
		logic [5:0] r;
		r = 6'h00;
		unique case (ph)
			ecb_pkg::PH_AB: r = ecb_pkg::ECB_CNT_ONE + {5'h00, c.ab_two} + (chg ? {4'h0, c.ab_ext} : 6'h00);
			ecb_pkg::PH_C: r = {4'h0, c.c_len};
			ecb_pkg::PH_D: r = {5'h00, c.d_len};
			ecb_pkg::PH_E: r = ecb_pkg::ECB_CNT_ONE + {1'b0, c.e_len};
			ecb_pkg::PH_F: r = {4'h0, c.f_len};
			default: r = 6'h00;
		endcase
		return r;
	endfunction : phase_len

	function automatic ecb_pkg::ecb_phase_t next_phase(input ecb_pkg::ecb_phase_t ph,
			input ecb_pkg::ecb_phase_timing_config_t c);
		ecb_pkg::ecb_phase_t r;
		r = ecb_pkg::PH_IDLE;
		for (int k = 5; k >= 1; k--) begin
			if (3'(k) > ph && phase_len(ecb_pkg::ecb_phase_t'(3'(k)), c, 1'b0) != 6'h00) begin
				r = ecb_pkg::ecb_phase_t'(3'(k));
			end
		end
		return r;
	endfunction : next_phase

	// lowest matching window wins, else no select
	function automatic logic [2:0] decode_cs(input logic [ecb_pkg::ECB_ADDR_W-1:0] a,
			input ecb_pkg::ecb_phase_timing_config_t c [ecb_pkg::ECB_NUM_CS]);
		logic [2:0] r;
		r = ecb_pkg::ECB_CS_NONE;
		for (int i = ecb_pkg::ECB_NUM_CS - 1; i >= 0; i--) begin
			if (((a[23:16] ^ c[i].win_base) & c[i].win_mask) == 8'h00) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : decode_cs

	// Pin levels for a phase; address stays put between accesses
	function automatic ecb_pkg::ecb_pins_t pins_for(input ecb_pkg::ecb_phase_t ph,
			input ecb_pkg::ecb_req_t q, input ecb_pkg::ecb_phase_timing_config_t c,
			input logic [2:0] cs);
		ecb_pkg::ecb_pins_t p;
		p = ecb_pkg::ECB_PINS_RESET;
		p.address_lines = q.addr;
		p.shared_out = q.addr[15:0];
		p.sep_out = q.wdata;
		if (ph != ecb_pkg::PH_IDLE) begin
			if (!cs[2]) begin
				p.cs_n[cs[1:0]] = 1'b0;
			end
			p.byte_high_enable_n = !q.byte_high_enable;
			p.ale = c.multiplexed_mode && ph == ecb_pkg::PH_AB;
			p.rd_n = !(ph == ecb_pkg::PH_E && !q.write);
			p.wr_n = !(ph == ecb_pkg::PH_E && q.write);
			// mux: address then write data on shared lines
			if (c.multiplexed_mode) begin
				p.shared_oe_n = !(ph == ecb_pkg::PH_AB || (q.write && ph != ecb_pkg::PH_C));
				if (q.write && ph >= ecb_pkg::PH_D) begin
					p.shared_out = q.wdata;
				end
			end else begin
				p.sep_oe_n = !(q.write && ph >= ecb_pkg::PH_D);
			end
		end
		return p;
	endfunction : pins_for

	////////////////////////////////////////////////////////////////////////////////
	// Handshake pin enters through the synchroniser
	ecb_sync #(
		.STAGES(SYNC_STAGES)
	) u_rdy_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.d_i(ready_i),
		.q_o(rdy_s)
	);

	// Sequencer next state
	always_comb begin
		cfg = cfg_i[st.cs[1:0]];
		// async mode reads the extra stage
		rdy_act = (cfg.rdy_async ? st.rdy_x : rdy_s) == cfg.rdy_pol;
		// without handshake only the count ends access
		step_done = st.cnt == 6'h00 && !(st.phase == ecb_pkg::PH_E && cfg.rdy_en && !rdy_act);
		new_cs = decode_cs(req_i.addr, cfg_i);
		nx = st;
		if (ce_i) begin
			// Pulse drops only on a running cycle, so a freeze holds it too
			nx.rsp_valid = 1'b0;
			nx.rdy_x = rdy_s;
			unique case (st.phase)
				ecb_pkg::PH_IDLE: begin
					if (req_valid_i) begin
						nx.req = req_i;
						nx.cs = new_cs;
						nx.win_chg = new_cs != st.last_cs;
						nx.last_cs = new_cs;
						nx.phase = ecb_pkg::PH_AB;
						nx.cnt = phase_len(ecb_pkg::PH_AB, cfg_i[new_cs[1:0]], nx.win_chg)
							- ecb_pkg::ECB_CNT_ONE;
					end
				end
				default: begin
					if (!step_done) begin
						nx.cnt = st.cnt == 6'h00 ? st.cnt : st.cnt - ecb_pkg::ECB_CNT_ONE;
					end else begin
						if (st.phase == ecb_pkg::PH_E) begin
							nx.rsp_valid = 1'b1;
							// capture on the edge that ends the strobe
							if (!st.req.write) begin
								nx.rdata = cfg.multiplexed_mode ? shared_address_data_lines_i
									: separate_data_lines_i;
							end
						end
						nx.phase = next_phase(st.phase, cfg);
						nx.cnt = phase_len(nx.phase, cfg, 1'b0) - ecb_pkg::ECB_CNT_ONE;
					end
				end
			endcase
			nx.pins = pins_for(nx.phase, nx.req, cfg_i[nx.cs[1:0]], nx.cs);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			st <= '{phase: ecb_pkg::PH_IDLE, cs: ecb_pkg::ECB_CS_NONE,
				last_cs: ecb_pkg::ECB_CS_NONE, pins: ecb_pkg::ECB_PINS_RESET, default: '0};
		end else begin
			st <= nx;
		end
	end

	// Outputs; the request port is open only between accesses
	assign req_ready_o = ce_i && st.phase == ecb_pkg::PH_IDLE;
	assign rsp_valid_o = st.rsp_valid;
	assign rdata_o = st.rdata;
	assign pins_o = st.pins;

	// system clock routed to the pin, fast driver on
	// Enable must change only while clk is low or the pulse is cut short
	assign clock_output_pin_signal_o = clk_i & bus_reference_clock_en_i;
	assign clk_hs_drv_o = bus_reference_clock_en_i;

	////////////////////////////////////////////////////////////////////////////////
	// Cycles spent in the current phase, for checking only
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pc <= 8'h00;
		end else if (ce_i) begin
			pc <= nx.phase != st.phase ? 8'h00 : (pc == 8'hFF ? pc : pc + 8'h01);
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_e_exit;
		st.phase == ecb_pkg::PH_E && ce_i && nx.phase != ecb_pkg::PH_E;
	endsequence

	sequence s_ab_exit;
		st.phase == ecb_pkg::PH_AB && ce_i && nx.phase != ecb_pkg::PH_AB;
	endsequence

	a_phase_order: assert property (
		(st.phase != ecb_pkg::PH_IDLE && ce_i) |=>
			(st.phase == ecb_pkg::PH_IDLE || st.phase >= $past(st.phase)))
		else $error("phase went backwards");
	a_cmd_delay: assert property (
		st.phase == ecb_pkg::PH_C |-> pc < 8'h03)
		else $error("command delay too long");
	a_setup_len: assert property (
		s_ab_exit ##0 !st.win_chg |-> pc == {7'h00, cfg.ab_two})
		else $error("address setup length wrong");
	a_wsetup_len: assert property (
		(st.phase == ecb_pkg::PH_D && ce_i) |=> st.phase != ecb_pkg::PH_D)
		else $error("write setup over one cycle");
	a_hold_len: assert property (
		s_e_exit ##1 (st.phase == ecb_pkg::PH_F && ce_i)[*4] |-> 1'b0)
		else $error("hold phase over three cycles");
	a_access_fixed: assert property (
		s_e_exit ##0 !cfg.rdy_en |-> pc == {3'h0, cfg.e_len})
		else $error("access length differs from count");
	a_ready_wait: assert property (
		(st.phase == ecb_pkg::PH_E && ce_i && cfg.rdy_en && !rdy_act) |=>
			st.phase == ecb_pkg::PH_E)
		else $error("access ended without handshake");
	a_read_capture: assert property (
		s_e_exit ##0 !st.req.write |=> rsp_valid_o && rdata_o ==
			$past(cfg.multiplexed_mode ? shared_address_data_lines_i : separate_data_lines_i))
		else $error("read data not captured at strobe end");
	a_demultiplexed_mode_data: assert property (
		(st.phase == ecb_pkg::PH_E && st.req.write && !cfg.multiplexed_mode) |->
			(!pins_o.sep_oe_n && pins_o.sep_out == st.req.wdata && pins_o.shared_oe_n))
		else $error("demultiplexed_mode write data not on data lines");
	a_ale_mux: assert property (
		(st.phase == ecb_pkg::PH_AB && cfg.multiplexed_mode) |-> pins_o.ale && !pins_o.shared_oe_n)
		else $error("address latch missing in setup");
	a_cs_onehot: assert property (
		$onehot0(~pins_o.cs_n))
		else $error("more than one chip select active");
endmodule : ecb_bus_cycle

// ---- hdl/ecb_pkg.sv ----
// What this block does
// - Up to five phases in fixed order per access; zero-length C, D, F skipped
// - Phase lengths from per-select timing config
// - Setup 1-2 cycles, plus 0-3 on window change
// - Write setup or turnaround: 0 or 1 cycle
// - Hold phase: 0 to 3 cycles
// - Access 1-32 cycles, or wait handshake governs
// - Software selects handshake active polarity
// - Asynchronous handshake adds an extra synchroniser stage
// - Read data captured at strobe end edge
// - Demultiplexed_mode: separate data lines; mux: shared lines
// - Reference clock is system clock on pin
// - Four chip selects, each with own timing
// - Unmatched addresses still run an external access
package ecb_pkg;
	localparam int ECB_NUM_CS = 4;
	localparam int ECB_SYNC_STAGES = 2;
	localparam int ECB_ADDR_W = 24;
	localparam int ECB_DATA_W = 16;
	localparam logic [5:0] ECB_CNT_ONE = 6'h01;
	localparam logic [2:0] ECB_CS_NONE = 3'h4;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_AB = 3'b001,
		PH_C = 3'b010,
		PH_D = 3'b011,
		PH_E = 3'b100,
		PH_F = 3'b101
	} ecb_phase_t;

	// Per chip-select timing, mode and address window
	typedef struct packed {
		logic ab_two;
		logic [1:0] ab_ext;
		logic [1:0] c_len;
		logic d_len;
		logic [4:0] e_len;
		logic [1:0] f_len;
		logic multiplexed_mode;
		logic rdy_en;
		logic rdy_pol;
		logic rdy_async;
		logic [7:0] win_base;
		logic [7:0] win_mask;
	} ecb_phase_timing_config_t;

	typedef struct packed {
		logic [ECB_ADDR_W-1:0] addr;
		logic [ECB_DATA_W-1:0] wdata;
		logic write;
		logic byte_high_enable;
	} ecb_req_t;

	typedef struct packed {
		logic [3:0] cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic byte_high_enable_n;
		logic [ECB_ADDR_W-1:0] address_lines;
		logic [ECB_DATA_W-1:0] shared_out;
		logic shared_oe_n;
		logic [ECB_DATA_W-1:0] sep_out;
		logic sep_oe_n;
	} ecb_pins_t;

	localparam ecb_pins_t ECB_PINS_RESET = '{cs_n: 4'hF, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
		byte_high_enable_n: 1'b1, address_lines: 24'h000000, shared_out: 16'h0000,
		shared_oe_n: 1'b1, sep_out: 16'h0000, sep_oe_n: 1'b1};

	typedef struct packed {
		ecb_phase_t phase;
		logic [5:0] cnt;
		ecb_req_t req;
		logic [2:0] cs;
		logic [2:0] last_cs;
		logic win_chg;
		logic rdy_x;
		logic [ECB_DATA_W-1:0] rdata;
		logic rsp_valid;
		ecb_pins_t pins;
	} ecb_state_t;
endpackage : ecb_pkg

// ---- hdl/ecb_sync.sv ----
`timescale 1ns/1ps
module ecb_sync #(
	parameter int STAGES = 2
) (
	// Clock and control
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	// Level in and out
	input wire logic d_i,
	output logic q_o
);
	logic [STAGES-1:0] sr;
	logic [STAGES-1:0] next_sr;

	// Shift only while enabled; only the last stage is visible
	always_comb begin
		next_sr = sr;
		if (ce_i) begin
			next_sr = {sr[STAGES-2:0], d_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sr <= '0;
		end else begin
			sr <= next_sr;
		end
	end

	assign q_o = sr[STAGES-1];
endmodule : ecb_sync

// ---- test/ecb_mem_model.sv ----
`timescale 1ns/1ps
module ecb_mem_model (
	// Clocks
	input wire logic clk_i,
	input wire logic lclk_i,
	// Bus pins and handshake setup
	input wire ecb_pkg::ecb_pins_t pins_i,
	input wire logic mux_i,
	input wire logic pol_i,
	input wire logic async_i,
	input wire logic [3:0] dly_i,
	// Driven back
	output logic [15:0] data_o,
	output logic ready_o
);
	logic [15:0] lat = 16'h0000;
	logic [15:0] junk = 16'h0F0F;
	logic [3:0] cnt = 4'h0;
	logic rs = 1'b0;
	logic rl = 1'b0;
	wire logic strobe = !(pins_i.rd_n && pins_i.wr_n);
	////////////////////////////////////////////////////////////
	// Latch mux address; junk toggles so a stale bus never matches
	always @(posedge clk_i) begin
		if (pins_i.ale) begin
			lat <= pins_i.shared_out;
		end
		junk <= ~junk;
	end
	assign data_o = !pins_i.rd_n ? ~(mux_i ? lat : pins_i.address_lines[15:0]) : junk;
	always @(posedge clk_i) begin
		cnt <= strobe ? cnt + 4'h1 : 4'h0;
		rs <= strobe && (cnt >= dly_i);
	end
	always @(posedge lclk_i) begin
		rl <= rs;
	end
	assign ready_o = (async_i ? (rl && rs) : rs) ? pol_i : !pol_i;
endmodule : ecb_mem_model

// ---- test/external_bus_cycle_control_tb_top.sv ----
`timescale 1ns/1ps
module external_bus_cycle_control_tb_top;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic req_valid = 1'b0;
	logic ref_en = 1'b0;
	logic multiplexed_mode = 1'b0;
	logic pol = 1'b1;
	logic asy = 1'b0;
	logic [3:0] dly = 4'hF;
	ecb_pkg::ecb_req_t req = '0;
	ecb_pkg::ecb_phase_timing_config_t cfg [ecb_pkg::ECB_NUM_CS];
	ecb_pkg::ecb_pins_t pins;
	logic [15:0] mdata;
	logic [15:0] rdata;
	logic rsp;
	logic rdy;
	logic cko;
	logic hs;
	logic req_ready;
	int miscompares = 0;
	int cmp_count = 0;
	// Wire level from both drivers
	wire logic [15:0] shared_w = pins.shared_oe_n ? mdata : pins.shared_out;
	wire logic [15:0] sep_w = pins.sep_oe_n ? mdata : pins.sep_out;
	////////////////////////////////////////////////////////////
	ecb_bus_cycle uut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce), .req_valid_i(req_valid),
		.req_i(req), .req_ready_o(req_ready), .rsp_valid_o(rsp), .rdata_o(rdata), .cfg_i(cfg),
		.bus_reference_clock_en_i(ref_en), .clock_output_pin_signal_o(cko), .clk_hs_drv_o(hs),
		.pins_o(pins), .shared_address_data_lines_i(shared_w), .separate_data_lines_i(sep_w),
		.ready_i(rdy));
	ecb_mem_model mem (.clk_i(clk), .lclk_i(lclk), .pins_i(pins), .mux_i(multiplexed_mode), .pol_i(pol),
		.async_i(asy), .dly_i(dly), .data_o(mdata), .ready_o(rdy));
	// System clock and unrelated handshake clock
	initial forever #5 clk = ~clk;
	initial begin
		#3;
		forever #80 lclk = ~lclk;
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// One access; ex is cycles to response, slack marks handshake waits
	task automatic acc(input logic [23:0] a, input logic w, input int cs, input int ex,
		input int f, input int slack);
		int n;
		int m;
		logic ale_seen;
		logic [15:0] wd;
		logic [15:0] rd;
		logic [3:0] sel;
		n = 1;
		m = 0;
		ale_seen = 1'b0;
		wd = a[15:0] ^ 16'h3C3C;
		rd = ~a[15:0];
		sel = (cs > 3) ? 4'hF : ~(4'h1 << cs);
		req = '{addr: a, wdata: wd, write: w, byte_high_enable: a[0]};
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		while (rsp !== 1'b1 && n < 80) begin
			if (pins.ale === 1'b1) ale_seen = 1'b1;
			if (!pins.rd_n || !pins.wr_n) begin
				chk(pins.cs_n, sel, "select");
				chk(pins.byte_high_enable_n, !a[0], "byte enable");
				chk(pins.address_lines, a, "address");
			end
			if (!pins.rd_n && multiplexed_mode) chk(pins.shared_oe_n, 1'b1, "turnaround");
			if (!pins.wr_n && multiplexed_mode) chk({pins.shared_oe_n, pins.shared_out}, wd, "mux data");
			if (!pins.wr_n && !multiplexed_mode) chk({pins.sep_oe_n, pins.sep_out}, wd, "sep data");
			@(negedge clk);
			n++;
		end
		if (slack == 0) chk(n, ex, "cycles");
		else chk(n >= ex + slack && n <= ex + 20, 1'b1, "wait");
		if (!w) chk(rdata, rd, "read data");
		chk(ale_seen, multiplexed_mode, "latch strobe");
		while (req_ready !== 1'b1 && m < 9) begin
			@(negedge clk);
			m++;
		end
		chk(m, f, "hold");
	endtask : acc
	////////////////////////////////////////////////////////////
	initial begin
		cfg[0] = '{1'b0, 2'h0, 2'h1, 1'b0, 5'h01, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'hFF};
		cfg[1] = '{1'b1, 2'h2, 2'h0, 1'b1, 5'h1F, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'hFF};
		cfg[2] = '{1'b0, 2'h1, 2'h2, 1'b1, 5'h00, 2'h0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h02, 8'hFF};
		cfg[3] = '{1'b1, 2'h3, 2'h3, 1'b0, 5'h00, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1, 8'h03, 8'hFF};
		repeat (6) @(negedge clk);
		chk(pins, ecb_pkg::ECB_PINS_RESET, "reset pins");
		rstn = 1'b1;
		@(posedge clk);
		#1 chk(cko, 1'b0, "ref off");
		@(negedge clk);
		ref_en = 1'b1;
		@(posedge clk);
		#1 chk({cko, hs}, 2'b11, "ref on");
		@(negedge clk);
		acc(24'h000010, 1'b0, 0, 5, 1, 0);
		acc(24'h000013, 1'b1, 0, 5, 1, 0);
		acc(24'h01ABCD, 1'b0, 1, 38, 3, 0);
		acc(24'h01ABCE, 1'b1, 1, 36, 3, 0);
		acc(24'h100044, 1'b0, 4, 5, 1, 0);
		multiplexed_mode = 1'b1;
		dly = 4'h3;
		acc(24'h02F0F1, 1'b0, 2, 7, 0, 2);
		acc(24'h02F0F2, 1'b1, 2, 6, 0, 2);
		multiplexed_mode = 1'b0;
		pol = 1'b0;
		asy = 1'b1;
		dly = 4'h0;
		acc(24'h030077, 1'b0, 3, 10, 2, 2);
		pol = 1'b1;
		asy = 1'b0;
		dly = 4'hF;
		// Enable low: a pending request must not be taken
		ce = 1'b0;
		req_valid = 1'b1;
		repeat (3) @(negedge clk);
		chk({req_ready, pins.cs_n}, 5'h0F, "frozen");
		ce = 1'b1;
		acc(24'h000020, 1'b0, 0, 5, 1, 0);
		results();
	end
	// Watchdog well beyond the expected run
	initial begin
		#20000;
		miscompares++;
		results();
	end
endmodule : external_bus_cycle_control_tb_top
